// ===== inc/xop_pkg.sv
package xop_pkg;
    localparam int          NUM_PORTS      = 4;
    localparam int          ADDR_W         = 12;
    localparam logic [3:0]  USB3_PORT_MASK = 4'h3;

    localparam logic [11:0] OFS_RING_LO    = 12'h018;
    localparam logic [11:0] OFS_RING_HI    = 12'h01c;
    localparam logic [11:0] OFS_DCBA_LO    = 12'h030;
    localparam logic [11:0] OFS_DCBA_HI    = 12'h034;
    localparam logic [11:0] OFS_CONFIG     = 12'h038;
    localparam logic [11:0] OFS_PORT_BASE  = 12'h400;
    localparam logic [11:0] OFS_PORT_STEP  = 12'h010;
    localparam logic [11:0] OFS_IRQ_STAT   = 12'h500;
    localparam logic [11:0] OFS_IRQ_CLEAR  = 12'h504;
    localparam logic [11:0] OFS_IRQ_ENABLE = 12'h508;

    localparam logic [31:0] RING_WR_MASK   = 32'hffffffc7;
    localparam int          RING_RUN_BIT   = 3;
    localparam int          RING_ABORT_BIT = 2;
    localparam int          RING_STOP_BIT  = 1;
    localparam logic [31:0] DCBA_WR_MASK   = 32'hffffffc0;
    localparam logic [31:0] CONFIG_WR_MASK = 32'h000000ff;
    localparam logic [63:0] REG64_RESET    = 64'h0;
    localparam logic [7:0]  CONFIG_RESET   = 8'h00;

    localparam int          PS_WARM        = 31;
    localparam int          PS_REMOVABLE   = 30;
    localparam int          PS_WAKE_LO     = 25;
    localparam int          PS_CFG_ERR_CHG = 23;
    localparam int          PS_LINK_CHG    = 22;
    localparam int          PS_RESET_CHG   = 21;
    localparam int          PS_OC_CHG      = 20;
    localparam int          PS_WARM_CHG    = 19;
    localparam int          PS_EN_CHG      = 18;
    localparam int          PS_CONN_CHG    = 17;
    localparam int          PS_LINK_STROBE = 16;
    localparam int          PS_IND_LO      = 14;
    localparam int          PS_SPEED_LO    = 10;
    localparam int          PS_POWER       = 9;
    localparam int          PS_LINK_LO     = 5;
    localparam int          PS_RESET       = 4;
    localparam int          PS_OC          = 3;
    localparam int          PS_ENABLED     = 1;
    localparam int          PS_CONNECT     = 0;
    localparam logic        POWER_RESET    = 1'b1;
    localparam logic [3:0]  LINK_RESET     = 4'h5;

    localparam logic [1:0]  RESP_OKAY      = 2'b00;
    localparam logic [1:0]  RESP_SLVERR    = 2'b10;
endpackage : xop_pkg

// ===== hdl/xop_regs.sv
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
module xop_regs
    import xop_pkg::*;
(
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire logic                     global_reset,
    input  wire logic                     hc_reset,
    input  wire logic [ADDR_W-1:0]        s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [ADDR_W-1:0]        s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    input  wire logic                     ring_running_flag,
    input  wire logic [NUM_PORTS-1:0]     non_removable_config,
    input  wire logic [NUM_PORTS-1:0]     connect_status_in,
    input  wire logic [NUM_PORTS-1:0]     overcurrent_in,
    input  wire logic [4*NUM_PORTS-1:0]   port_speed_in,
    input  wire logic [NUM_PORTS-1:0]     link_state_evt,
    input  wire logic [4*NUM_PORTS-1:0]   link_state_in,
    input  wire logic [NUM_PORTS-1:0]     reset_done_evt,
    input  wire logic [NUM_PORTS-1:0]     config_error_evt,
    output logic [63:0]                   command_ring_ctrl,
    output logic [63:0]                   context_array_base,
    output logic [7:0]                    max_slots_enabled,
    output logic [NUM_PORTS-1:0]          port_power,
    output logic [4*NUM_PORTS-1:0]        port_link_state,
    output logic [NUM_PORTS-1:0]          link_write_strobe,
    output logic [NUM_PORTS-1:0]          port_reset,
    output logic [NUM_PORTS-1:0]          warm_port_reset,
    output logic [NUM_PORTS-1:0]          port_enabled,
    output logic [3*NUM_PORTS-1:0]        wake_enables,
    output logic                          irq
);

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb,
                                          input logic [31:0] wmask);
        logic [31:0] be;
        be = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
        merge = (old_v & ~be) | (new_v & be);
    endfunction : merge

    function automatic logic port_hit(input logic [ADDR_W-1:0] addr, input int idx);
        port_hit = (addr == OFS_PORT_BASE + OFS_PORT_STEP * idx[11:0]);
    endfunction : port_hit

    // Write and read channel holding registers
    logic                   aw_held_r;
    logic                   w_held_r;
    logic [ADDR_W-1:0]      waddr_r;
    logic [31:0]            wdata_r;
    logic [3:0]             wstrb_r;
    logic                   bvalid_r;
    logic [1:0]             bresp_r;
    logic                   rvalid_r;
    logic [1:0]             rresp_r;
    logic [31:0]            rdata_r;
    logic                   wr_go;
    logic                   rd_go;

    logic [63:0]            ring_r;
    logic [63:0]            dcba_r;
    logic [7:0]             config_r;
    logic [NUM_PORTS-1:0]   irq_stat_r;
    logic [NUM_PORTS-1:0]   irq_en_r;

    logic [NUM_PORTS-1:0]   wake_oc_r, wake_disc_r, wake_conn_r;
    logic [NUM_PORTS-1:0]   cfg_chg_r, link_chg_r, reset_chg_r, oc_chg_r;
    logic [NUM_PORTS-1:0]   warm_chg_r, en_chg_r, conn_chg_r;
    logic [NUM_PORTS-1:0]   power_r, reset_r, warm_r, enabled_r;
    logic [NUM_PORTS-1:0]   conn_prev_r, oc_prev_r;
    logic [NUM_PORTS-1:0]   lws_r;
    logic [1:0]             ind_r  [NUM_PORTS];
    logic [3:0]             link_r [NUM_PORTS];
    logic [31:0]            port_view [NUM_PORTS];
    logic [NUM_PORTS-1:0]   wr_port, rd_port, port_evt;
    logic                   wr_mapped;
    logic                   rd_mapped;
    logic [31:0]            rd_value;

    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready  = !w_held_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;
    assign wr_go         = aw_held_r && w_held_r && !bvalid_r;
    assign rd_go         = s_axi_arvalid && !rvalid_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            waddr_r   <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            waddr_r   <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            wdata_r  <= '0;
            wstrb_r  <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
        end else if (wr_go) begin
            w_held_r <= 1'b0;
        end
    end

    always_comb begin
        wr_mapped = (waddr_r == OFS_RING_LO) || (waddr_r == OFS_RING_HI)
                 || (waddr_r == OFS_DCBA_LO) || (waddr_r == OFS_DCBA_HI)
                 || (waddr_r == OFS_CONFIG)  || (waddr_r == OFS_IRQ_STAT)
                 || (waddr_r == OFS_IRQ_CLEAR) || (waddr_r == OFS_IRQ_ENABLE);
        for (int i = 0; i < NUM_PORTS; i++) begin
            wr_port[i] = wr_go && port_hit(waddr_r, i);
            rd_port[i] = rd_go && port_hit(s_axi_araddr, i);
            wr_mapped  = wr_mapped || port_hit(waddr_r, i);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Non-sticky controller registers also clear on controller reset
    always_ff @(posedge aclk) begin
        if (!aresetn || global_reset || hc_reset) begin
            ring_r   <= REG64_RESET;
            dcba_r   <= REG64_RESET;
            config_r <= CONFIG_RESET;
        end else if (wr_go) begin
            case (waddr_r)
                OFS_RING_LO: ring_r[31:0]  <= merge(ring_r[31:0], wdata_r, wstrb_r,
                                                    RING_WR_MASK);
                OFS_RING_HI: ring_r[63:32] <= merge(ring_r[63:32], wdata_r, wstrb_r,
                                                    32'hffffffff);
                OFS_DCBA_LO: dcba_r[31:0]  <= merge(dcba_r[31:0], wdata_r, wstrb_r,
                                                    DCBA_WR_MASK);
                OFS_DCBA_HI: dcba_r[63:32] <= merge(dcba_r[63:32], wdata_r, wstrb_r,
                                                    32'hffffffff);
                OFS_CONFIG:  config_r      <= 8'(merge({24'h0, config_r}, wdata_r, wstrb_r,
                                                       CONFIG_WR_MASK));
                default: ;
            endcase
        end
    end

    // Port engine inputs and the sticky port fields
    always_ff @(posedge aclk) begin
        if (!aresetn || global_reset) begin
            wake_oc_r   <= '0;
            wake_disc_r <= '0;
            wake_conn_r <= '0;
            cfg_chg_r   <= '0;
            link_chg_r  <= '0;
            reset_chg_r <= '0;
            oc_chg_r    <= '0;
            warm_chg_r  <= '0;
            en_chg_r    <= '0;
            conn_chg_r  <= '0;
            power_r     <= {NUM_PORTS{POWER_RESET}};
            reset_r     <= '0;
            warm_r      <= '0;
            enabled_r   <= '0;
            conn_prev_r <= '0;
            oc_prev_r   <= '0;
            lws_r       <= '0;
            for (int i = 0; i < NUM_PORTS; i++) begin
                ind_r[i]  <= 2'h0;
                link_r[i] <= LINK_RESET;
            end
        end else begin
            conn_prev_r <= connect_status_in;
            oc_prev_r   <= overcurrent_in;
            for (int i = 0; i < NUM_PORTS; i++) begin
                lws_r[i] <= wr_port[i] && wstrb_r[2] && wdata_r[PS_LINK_STROBE];
                // Software writes first, hardware events after so they win
                if (wr_port[i]) begin
                    if (wstrb_r[3]) begin
                        wake_oc_r[i]   <= wdata_r[PS_WAKE_LO+2];
                        wake_disc_r[i] <= wdata_r[PS_WAKE_LO+1];
                        wake_conn_r[i] <= wdata_r[PS_WAKE_LO];
                        if (USB3_PORT_MASK[i] && wdata_r[PS_WARM])
                            warm_r[i] <= 1'b1;
                    end
                    if (wstrb_r[1]) begin
                        ind_r[i]   <= wdata_r[PS_IND_LO+:2];
                        power_r[i] <= wdata_r[PS_POWER];
                        if (wstrb_r[2] && wdata_r[PS_LINK_STROBE])
                            link_r[i] <= wdata_r[PS_LINK_LO+:4];
                    end
                    if (wstrb_r[0]) begin
                        if (wdata_r[PS_RESET])
                            reset_r[i] <= 1'b1;
                        if (wdata_r[PS_LINK_LO+:3] != 3'h0 && wstrb_r[1]
                            && wstrb_r[2] && wdata_r[PS_LINK_STROBE])
                            link_r[i] <= wdata_r[PS_LINK_LO+:4];
                    end
                end
                // Read of the port register clears its change flags, the enable and the warm reset bit
                if (rd_port[i]) begin
                    link_chg_r[i]  <= 1'b0;
                    reset_chg_r[i] <= 1'b0;
                    oc_chg_r[i]    <= 1'b0;
                    en_chg_r[i]    <= 1'b0;
                    conn_chg_r[i]  <= 1'b0;
                    enabled_r[i]   <= 1'b0;
                    cfg_chg_r[i]   <= 1'b0;
                    warm_chg_r[i]  <= 1'b0;
                    warm_r[i]      <= 1'b0;
                end
                if (connect_status_in[i] != conn_prev_r[i])
                    conn_chg_r[i] <= 1'b1;
                if (overcurrent_in[i] != oc_prev_r[i])
                    oc_chg_r[i] <= 1'b1;
                if (link_state_evt[i]) begin
                    link_chg_r[i] <= 1'b1;
                    link_r[i]     <= link_state_in[4*i+:4];
                end
                if (config_error_evt[i] && USB3_PORT_MASK[i])
                    cfg_chg_r[i] <= 1'b1;
                if (reset_done_evt[i] && (reset_r[i] || warm_r[i])) begin
                    reset_r[i]     <= 1'b0;
                    reset_chg_r[i] <= 1'b1;
                    enabled_r[i]   <= connect_status_in[i];
                    if (warm_r[i]) begin
                        warm_r[i]     <= 1'b0;
                        warm_chg_r[i] <= 1'b1;
                    end
                end
                // Disconnect drops the enable and records the change
                if (!connect_status_in[i] && enabled_r[i]) begin
                    enabled_r[i] <= 1'b0;
                    en_chg_r[i]  <= 1'b1;
                end
            end
        end
    end

    // One event per port: any change flag newly raised by hardware
    always_comb begin
        for (int i = 0; i < NUM_PORTS; i++) begin
            port_evt[i] = (connect_status_in[i] != conn_prev_r[i])
                       || (overcurrent_in[i] != oc_prev_r[i])
                       || link_state_evt[i]
                       || (config_error_evt[i] && USB3_PORT_MASK[i])
                       || (reset_done_evt[i] && (reset_r[i] || warm_r[i]))
                       || (!connect_status_in[i] && enabled_r[i]);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_r <= '0;
            irq_en_r   <= '0;
        end else begin
            if (wr_go && waddr_r == OFS_IRQ_ENABLE && wstrb_r[0])
                irq_en_r <= wdata_r[NUM_PORTS-1:0];
            // Set wins over a clear in the same cycle
            irq_stat_r <= (irq_stat_r & ~((wr_go && waddr_r == OFS_IRQ_CLEAR && wstrb_r[0])
                                          ? wdata_r[NUM_PORTS-1:0] : '0)) | port_evt;
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_PORTS; i++) begin
            port_view[i]                  = 32'h0;
            port_view[i][PS_WARM]         = USB3_PORT_MASK[i] && warm_r[i];
            port_view[i][PS_REMOVABLE]    = non_removable_config[i];
            port_view[i][PS_WAKE_LO+2]    = wake_oc_r[i];
            port_view[i][PS_WAKE_LO+1]    = wake_disc_r[i];
            port_view[i][PS_WAKE_LO]      = wake_conn_r[i];
            port_view[i][PS_CFG_ERR_CHG]  = USB3_PORT_MASK[i] && cfg_chg_r[i];
            port_view[i][PS_LINK_CHG]     = link_chg_r[i];
            port_view[i][PS_RESET_CHG]    = reset_chg_r[i];
            port_view[i][PS_OC_CHG]       = oc_chg_r[i];
            port_view[i][PS_WARM_CHG]     = USB3_PORT_MASK[i] && warm_chg_r[i];
            port_view[i][PS_EN_CHG]       = en_chg_r[i];
            port_view[i][PS_CONN_CHG]     = conn_chg_r[i];
            port_view[i][PS_IND_LO+:2]    = ind_r[i];
            port_view[i][PS_SPEED_LO+:4]  = port_speed_in[4*i+:4];
            port_view[i][PS_POWER]        = power_r[i];
            port_view[i][PS_LINK_LO+:4]   = link_r[i];
            port_view[i][PS_RESET]        = reset_r[i];
            port_view[i][PS_OC]           = overcurrent_in[i];
            port_view[i][PS_ENABLED]      = enabled_r[i];
            port_view[i][PS_CONNECT]      = connect_status_in[i];
        end
    end

    always_comb begin
        rd_mapped = 1'b1;
        rd_value  = 32'h0;
        case (s_axi_araddr)
            OFS_RING_LO: begin
                rd_value               = ring_r[31:0] & RING_WR_MASK;
                rd_value[RING_RUN_BIT] = ring_running_flag;
            end
            OFS_RING_HI:    rd_value = ring_r[63:32];
            OFS_DCBA_LO:    rd_value = dcba_r[31:0] & DCBA_WR_MASK;
            OFS_DCBA_HI:    rd_value = dcba_r[63:32];
            OFS_CONFIG:     rd_value = {24'h0, config_r};
            OFS_IRQ_STAT:   rd_value = {{(32-NUM_PORTS){1'b0}}, irq_stat_r};
            OFS_IRQ_CLEAR:  rd_value = 32'h0;
            OFS_IRQ_ENABLE: rd_value = {{(32-NUM_PORTS){1'b0}}, irq_en_r};
            default:        rd_mapped = 1'b0;
        endcase
        for (int i = 0; i < NUM_PORTS; i++) begin
            if (port_hit(s_axi_araddr, i)) begin
                rd_value  = port_view[i];
                rd_mapped = 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rresp_r  <= RESP_OKAY;
            rdata_r  <= 32'h0;
        end else if (rd_go) begin
            rvalid_r <= 1'b1;
            rresp_r  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            rdata_r  <= rd_value;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_PORTS; i++) begin
            port_link_state[4*i+:4] = link_r[i];
            wake_enables[3*i+:3]    = {wake_oc_r[i], wake_disc_r[i], wake_conn_r[i]};
        end
    end

    assign command_ring_ctrl  = {ring_r[63:32], ring_r[31:0] & RING_WR_MASK};
    assign context_array_base = {dcba_r[63:32], dcba_r[31:0] & DCBA_WR_MASK};
    assign max_slots_enabled  = config_r;
    assign port_power         = power_r;
    assign link_write_strobe  = lws_r;
    assign port_reset         = reset_r;
    assign warm_port_reset    = warm_r & USB3_PORT_MASK;
    assign port_enabled       = enabled_r;
    assign irq                = |(irq_stat_r & irq_en_r);

endmodule : xop_regs

// ===== verif/xop_monitor.sv
`timescale 1ns/1ps
module xop_monitor
    import xop_pkg::*;
(
    input logic        aclk,
    input logic        aresetn,
    input logic        global_reset,
    input logic        hc_reset,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [31:0] s_axi_rdata,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic [63:0] command_ring_ctrl,
    input logic [63:0] context_array_base,
    input logic [7:0]  max_slots_enabled,
    input logic [3:0]  port_power,
    input logic [15:0] port_link_state,
    input logic [3:0]  link_write_strobe
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    a_ring_reserved: assert property (command_ring_ctrl[5:3] == 3'h0)
        else $error("ring control reserved bits set");
    a_base_reserved: assert property (context_array_base[5:0] == 6'h00)
        else $error("context base reserved bits set");
    a_reset_values: assert property ($rose(aresetn) |-> port_power == 4'hf && port_link_state == 16'h5555 && command_ring_ctrl == 64'h0)
        else $error("wrong values after reset");
    a_global_sticky: assert property (global_reset |=> port_power == 4'hf && port_link_state == 16'h5555)
        else $error("port fields kept over global reset");
    a_hc_scope: assert property (hc_reset && !global_reset |=> max_slots_enabled == 8'h00 && $stable(port_power))
        else $error("controller reset scope wrong");
    a_strobe_pulse: assert property (|link_write_strobe |=> link_write_strobe == 4'h0)
        else $error("link strobe longer than one cycle");
    cover property (link_write_strobe[0]);
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rready);
endmodule : xop_monitor

// ===== verif/tb.sv
`timescale 1ns/1ps
module tb
    import xop_pkg::*;
;
    logic        aclk = 1'b0, aresetn = 1'b0, global_reset = 1'b0, hc_reset = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1, ring_running_flag = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf, non_removable_config = 4'h5, connect_status_in = 4'h0;
    logic [3:0]  overcurrent_in = 4'h0, link_state_evt = 4'h0, reset_done_evt = 4'h0;
    logic [3:0]  config_error_evt = 4'h0;
    logic [15:0] port_speed_in = 16'h0, link_state_in = 16'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp, br, rr;
    logic [31:0] s_axi_rdata, rq;
    logic [63:0] command_ring_ctrl, context_array_base;
    logic [7:0]  max_slots_enabled;
    logic [3:0]  port_power, link_write_strobe, port_reset, warm_port_reset, port_enabled;
    logic [15:0] port_link_state;
    logic [11:0] wake_enables;
    logic [31:0] pins;
    int          fail_count = 0, n_tests = 0, cyc = 0;
    logic [11:0] ofs [5] = '{12'h018, 12'h01c, 12'h030, 12'h034, 12'h038};
    logic [31:0] msk [5] = '{32'hffffffc7, 32'hffffffff, 32'hffffffc0, 32'hffffffff, 32'h000000ff};

    xop_regs dut (.*);

    // Port-side outputs packed for one compare
    assign pins = {4'h0, link_write_strobe, port_reset, warm_port_reset, port_enabled,
                   wake_enables};

    always #20 aclk = ~aclk;

    // Watchdog: a hung handshake ends the run as a failure
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            results();
        end
    end

    task automatic results();
        if (fail_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %s exp %h got %h", nm, e, s);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        // Each channel drops at the edge that takes it
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready));
        br = s_axi_bresp;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid && s_axi_rready));
        rq = s_axi_rdata;
        rr = s_axi_rresp;
        chk("rdata", e, rq);
    endtask : rd

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(12'h400 + 12'(16 * i), 32'h000002a0 | {non_removable_config[i], 30'h0});
        end
        for (int i = 0; i < 5; i++) begin
            rd(ofs[i], 32'h0);
            wr(ofs[i], 32'hffffffff);
            rd(ofs[i], msk[i]);
        end
        chk("ring_lo", 32'hffffffc7, command_ring_ctrl[31:0]);
        chk("base_lo", 32'hffffffc0, context_array_base[31:0]);
        chk("slots", 32'h000000ff, 32'(max_slots_enabled));
        @(posedge aclk);
        ring_running_flag <= 1'b1;
        rd(12'h018, 32'hffffffcf);
        @(posedge aclk);
        ring_running_flag <= 1'b0;
        hc_reset <= 1'b1;
        @(posedge aclk);
        hc_reset <= 1'b0;
        for (int i = 0; i < 5; i++) rd(ofs[i], 32'h0);
        wr(12'h100, 32'hffffffff);
        chk("bresp", 32'(RESP_SLVERR), 32'(br));
        rd(12'h100, 32'h0);
        chk("rresp", 32'(RESP_SLVERR), 32'(rr));
        // Same write to a USB3 port and a USB2 port
        for (int i = 0; i < 3; i += 2) begin
            wr(12'h400 + 12'(16 * i), 32'hbf01c074);
            chk("pin", i == 0 ? 32'h01110007 : 32'h045001c7, pins);
            rd(12'h400 + 12'(16 * i), 32'h4e00c070 | {~i[1], 31'h0});
            rd(12'h400 + 12'(16 * i), 32'h4e00c070);
        end
        @(posedge aclk);
        reset_done_evt <= 4'h1;
        @(posedge aclk);
        reset_done_evt <= 4'h0;
        rd(12'h400, 32'h4e20c060);
        wr(12'h508, 32'h0);
        @(posedge aclk);
        connect_status_in <= 4'h2;
        overcurrent_in <= 4'h2;
        port_speed_in <= 16'h0040;
        link_state_in <= 16'h0020;
        link_state_evt <= 4'h2;
        config_error_evt <= 4'ha;
        @(posedge aclk);
        link_state_evt <= 4'h0;
        config_error_evt <= 4'h0;
        wr(12'h508, 32'h0);
        chk("irq", 32'h0, 32'(irq));
        wr(12'h508, 32'hf);
        chk("irq", 32'h1, 32'(irq));
        rd(12'h410, 32'h00d21249);
        rd(12'h430, 32'h000002a0);
        rd(12'h410, 32'h00001249);
        wr(12'h504, 32'hf);
        chk("irq", 32'h0, 32'(irq));
        @(posedge aclk);
        global_reset <= 1'b1;
        @(posedge aclk);
        global_reset <= 1'b0;
        rd(12'h400, 32'h400002a0);
        results();
    end
endmodule : tb

bind xop_regs xop_monitor mon (.*);
